// file: rtcaf_pkg.sv
// package: register map, field positions, reset values and timing for the alarm/century/flags block
`default_nettype none
package rtcaf_pkg;
	localparam logic [16:0] OFF_FLAGS = 17'h1_fff0;
	localparam logic [16:0] OFF_CENTURY = 17'h1_fff1;
	localparam logic [16:0] OFF_ALM_SEC = 17'h1_fff2;
	localparam logic [19:0] ADDR_FLAGS = 20'h7_ffc0;
	localparam logic [19:0] ADDR_CENTURY = 20'h7_ffc4;
	localparam logic [19:0] ADDR_ALM_SEC = 20'h7_ffc8;
	localparam logic [19:0] ADDR_TIME_SEC = 20'h0_0000;
	localparam int FLAG_WDOG = 7;
	localparam int FLAG_ALARM = 6;
	localparam int FLAG_PFAIL = 5;
	localparam int FLAG_OSC = 4;
	localparam int FLAG_CAL = 2;
	localparam int FLAG_WHOLD = 1;
	localparam int FLAG_RFREEZE = 0;
	localparam int ALM_MASK = 7;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_CENTURY = 8'h00;
	localparam logic [7:0] RST_ALM_SEC = 8'h00;
	localparam logic [7:0] RST_SEC = 8'h00;
	localparam int CLK_HZ = 100_000_000;
	localparam int CAL_HZ = 512;
	localparam int CAL_HALF_CYC = CLK_HZ / (2 * CAL_HZ);
	localparam int SEC_CYC = CLK_HZ;
endpackage : rtcaf_pkg
`default_nettype wire

// file: rtcaf_divider.sv
// divider: one-cycle enable pulse every DIV cycles
`default_nettype none
module rtcaf_divider #(
	parameter int DIV = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} rtcaf_div_s;
	rtcaf_div_s st_reg;
	rtcaf_div_s st_next;
	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (clr)
			st_next.cnt = 32'h0000_0000;
		else if (st_reg.cnt >= 32'(DIV - 1))
		begin
			st_next.cnt = 32'h0000_0000;
			st_next.tick = 1'b1;
		end
		else
			st_next.cnt = st_reg.cnt + 32'h0000_0001;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign tick = st_reg.tick;
endmodule // rtcaf_divider
`default_nettype wire

// file: rtcaf_bcd_digit.sv
// one BCD digit counter with carry
`default_nettype none
module rtcaf_bcd_digit #(
	parameter logic [3:0] MAX = 4'h9
) (
	input wire logic [3:0] val,
	input wire logic inc,
	output logic [3:0] nxt,
	output logic carry
);
	always_comb
	begin
		carry = inc && (val >= MAX);
		if (!inc)
			nxt = val;
		else if (val >= MAX)
			nxt = 4'h0;
		else
			nxt = val + 4'h1;
	end
endmodule // rtcaf_bcd_digit
`default_nettype wire

// file: rtcaf_top.sv
// alarm seconds, BCD centuries and flags registers behind an APB slave
`default_nettype none
// Operation
// - seconds alarm: mask bit plus BCD value
// - mask zero: seconds compared with time
// - mask one: seconds ignored in match
// - alarm match sets alarm flag
// - alarm flag cleared by flags read
// - supply below switchover sets power flag
// - power flag cleared by flags read
module rtcaf_top #(
	parameter int SEC_CYCLES = rtcaf_pkg::SEC_CYC,
	parameter int CAL_CYCLES = rtcaf_pkg::CAL_HALF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [19:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic other_alarm_match,
	input wire logic year_rollover,
	input wire logic watchdog_zero,
	input wire logic below_switchover,
	input wire logic int_request,
	output logic int_pin,
	output logic [7:0] seconds_now,
	output logic alarm_match
);
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] century;
		logic [7:0] alm_sec;
		logic [7:0] sec;
		logic [7:0] century_hold;
		logic [7:0] sec_hold;
		logic hold_dirty;
		logic [7:0] century_snap;
		logic [7:0] sec_snap;
		logic [31:0] prdata;
		logic cal_wave;
		logic match_d;
		logic ready;
	} rtcaf_state_s;
	rtcaf_state_s st_reg;
	rtcaf_state_s st_next;
	logic sec_tick;
	logic cal_tick;
	logic acc;
	logic wr;
	logic rd;
	logic mapped;
	logic match_now;
	logic [3:0] su_n;
	logic [3:0] st_n;
	logic [3:0] cu_n;
	logic [3:0] ct_n;
	logic su_c;
	logic st_c;
	logic cu_c;
	logic ct_c;
	logic [7:0] wb;
	rtcaf_divider #(.DIV(SEC_CYCLES)) u_sec_div (
		.pclk(pclk),
		.presetn(presetn),
		.clr(1'b0),
		.tick(sec_tick)
	);
	rtcaf_divider #(.DIV(CAL_CYCLES)) u_cal_div (
		.pclk(pclk),
		.presetn(presetn),
		.clr(!st_reg.flags[rtcaf_pkg::FLAG_CAL]),
		.tick(cal_tick)
	);
	rtcaf_bcd_digit #(.MAX(4'h9)) u_sec_u (
		.val(st_reg.sec[3:0]),
		.inc(sec_tick),
		.nxt(su_n),
		.carry(su_c)
	);
	rtcaf_bcd_digit #(.MAX(4'h5)) u_sec_t (
		.val(st_reg.sec[7:4]),
		.inc(su_c),
		.nxt(st_n),
		.carry(st_c)
	);
	// centuries advance on the year counter's wrap from 99 to 00
	rtcaf_bcd_digit #(.MAX(4'h9)) u_cen_u (
		.val(st_reg.century[3:0]),
		.inc(year_rollover),
		.nxt(cu_n),
		.carry(cu_c)
	);
	rtcaf_bcd_digit #(.MAX(4'h9)) u_cen_t (
		.val(st_reg.century[7:4]),
		.inc(cu_c),
		.nxt(ct_n),
		.carry(ct_c)
	);
	// act on the first access cycle only, so a flag set there is not cleared unseen
	assign acc = psel && penable && !st_reg.ready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign wb = pwdata[7:0];
	assign mapped = (paddr == rtcaf_pkg::ADDR_FLAGS) || (paddr == rtcaf_pkg::ADDR_CENTURY)
		|| (paddr == rtcaf_pkg::ADDR_ALM_SEC) || (paddr == rtcaf_pkg::ADDR_TIME_SEC);
	// masked seconds leave the match to the other alarm fields
	assign match_now = other_alarm_match && (st_reg.alm_sec[rtcaf_pkg::ALM_MASK]
		|| (st_reg.alm_sec[6:0] == st_reg.sec[6:0]));
	always_comb
	begin
		st_next = st_reg;
		st_next.match_d = match_now;
		// read data is registered at the access edge, so pready waits one cycle
		st_next.ready = psel && penable && !st_reg.ready;
		st_next.sec = {st_n, su_n};
		st_next.century = {ct_n, cu_n};
		if (st_reg.flags[rtcaf_pkg::FLAG_CAL] && cal_tick)
			st_next.cal_wave = !st_reg.cal_wave;
		else if (!st_reg.flags[rtcaf_pkg::FLAG_CAL])
			st_next.cal_wave = 1'b0;
		if (rd && paddr == rtcaf_pkg::ADDR_FLAGS)
		begin
			st_next.flags[rtcaf_pkg::FLAG_ALARM] = 1'b0;
			st_next.flags[rtcaf_pkg::FLAG_PFAIL] = 1'b0;
			st_next.flags[rtcaf_pkg::FLAG_WDOG] = 1'b0;
		end
		if (wr)
		begin
			case (paddr)
				rtcaf_pkg::ADDR_FLAGS:
				begin
					st_next.flags[rtcaf_pkg::FLAG_CAL] = wb[rtcaf_pkg::FLAG_CAL];
					st_next.flags[rtcaf_pkg::FLAG_WHOLD] = wb[rtcaf_pkg::FLAG_WHOLD];
					st_next.flags[rtcaf_pkg::FLAG_RFREEZE] = wb[rtcaf_pkg::FLAG_RFREEZE];
					if (!wb[rtcaf_pkg::FLAG_OSC])
						st_next.flags[rtcaf_pkg::FLAG_OSC] = 1'b0;
				end
				rtcaf_pkg::ADDR_CENTURY:
				begin
					st_next.century_hold = wb;
					st_next.hold_dirty = 1'b1;
				end
				rtcaf_pkg::ADDR_ALM_SEC:
					st_next.alm_sec = wb;
				rtcaf_pkg::ADDR_TIME_SEC:
				begin
					st_next.sec_hold = wb;
					st_next.hold_dirty = 1'b1;
				end
				default:
					st_next.flags = st_next.flags;
			endcase
		end
		// clearing write hold moves the staged time into the counters
		if (st_reg.flags[rtcaf_pkg::FLAG_WHOLD] && !st_next.flags[rtcaf_pkg::FLAG_WHOLD]
			&& st_reg.hold_dirty)
		begin
			st_next.century = st_reg.century_hold;
			st_next.sec = st_reg.sec_hold;
			st_next.hold_dirty = 1'b0;
		end
		else if (!st_reg.flags[rtcaf_pkg::FLAG_WHOLD] && st_reg.hold_dirty)
		begin
			st_next.century = st_reg.century_hold;
			st_next.sec = st_reg.sec_hold;
			st_next.hold_dirty = 1'b0;
		end
		// snapshot follows the counters only while freeze is off
		if (!st_reg.flags[rtcaf_pkg::FLAG_RFREEZE])
		begin
			st_next.century_snap = st_reg.century;
			st_next.sec_snap = st_reg.sec;
		end
		// sets come last so an event in the read cycle survives
		if (match_now && !st_reg.match_d)
			st_next.flags[rtcaf_pkg::FLAG_ALARM] = 1'b1;
		if (watchdog_zero)
			st_next.flags[rtcaf_pkg::FLAG_WDOG] = 1'b1;
		if (below_switchover)
			st_next.flags[rtcaf_pkg::FLAG_PFAIL] = 1'b1;
		st_next.prdata = 32'h0000_0000;
		if (rd)
		begin
			case (paddr)
				rtcaf_pkg::ADDR_FLAGS:
					st_next.prdata = {24'h00_0000, st_reg.flags[7:4], 1'b0, st_reg.flags[2:0]};
				rtcaf_pkg::ADDR_CENTURY:
					st_next.prdata = {24'h00_0000, st_reg.century_snap};
				rtcaf_pkg::ADDR_ALM_SEC:
					st_next.prdata = {24'h00_0000, st_reg.alm_sec};
				rtcaf_pkg::ADDR_TIME_SEC:
					st_next.prdata = {24'h00_0000, st_reg.sec_snap};
				default:
					st_next.prdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= '0;
			st_reg.flags <= rtcaf_pkg::RST_FLAGS;
			st_reg.century <= rtcaf_pkg::RST_CENTURY;
			st_reg.alm_sec <= rtcaf_pkg::RST_ALM_SEC;
			st_reg.sec <= rtcaf_pkg::RST_SEC;
		end
		else
			st_reg <= st_next;
	end
	assign pready = st_reg.ready;
	assign pslverr = st_reg.ready && !mapped;
	assign prdata = st_reg.prdata;
	assign int_pin = st_reg.flags[rtcaf_pkg::FLAG_CAL] ? st_reg.cal_wave : int_request;
	assign seconds_now = st_reg.sec;
	assign alarm_match = st_reg.match_d;
	property p_af_set;
		@(posedge pclk) disable iff (!presetn)
		match_now && !st_reg.match_d |=> st_reg.flags[rtcaf_pkg::FLAG_ALARM];
	endproperty
	a_af_set: assert property (p_af_set)
		else $error("alarm flag not set on match");
	property p_af_clr;
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == rtcaf_pkg::ADDR_FLAGS && !match_now
		|=> !st_reg.flags[rtcaf_pkg::FLAG_ALARM];
	endproperty
	a_af_clr: assert property (p_af_clr)
		else $error("alarm flag not cleared by read");
	property p_af_keep;
		@(posedge pclk) disable iff (!presetn)
		st_reg.flags[rtcaf_pkg::FLAG_ALARM] && !(rd && paddr == rtcaf_pkg::ADDR_FLAGS)
		|=> st_reg.flags[rtcaf_pkg::FLAG_ALARM];
	endproperty
	a_af_keep: assert property (p_af_keep)
		else $error("alarm flag lost without a read");
	property p_pf_set;
		@(posedge pclk) disable iff (!presetn)
		below_switchover |=> st_reg.flags[rtcaf_pkg::FLAG_PFAIL];
	endproperty
	a_pf_set: assert property (p_pf_set)
		else $error("power flag not set");
	property p_pf_clr;
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == rtcaf_pkg::ADDR_FLAGS && !below_switchover
		|=> !st_reg.flags[rtcaf_pkg::FLAG_PFAIL];
	endproperty
	a_pf_clr: assert property (p_pf_clr)
		else $error("power flag not cleared by read");
	property p_wdf;
		@(posedge pclk) disable iff (!presetn)
		watchdog_zero |=> st_reg.flags[rtcaf_pkg::FLAG_WDOG];
	endproperty
	a_wdf: assert property (p_wdf)
		else $error("watchdog flag not set");
	property p_mask;
		@(posedge pclk) disable iff (!presetn)
		st_reg.alm_sec[rtcaf_pkg::ALM_MASK] && other_alarm_match |-> match_now;
	endproperty
	a_mask: assert property (p_mask)
		else $error("masked seconds blocked match");
	property p_cmp;
		@(posedge pclk) disable iff (!presetn)
		!st_reg.alm_sec[rtcaf_pkg::ALM_MASK] && st_reg.alm_sec[6:0] != st_reg.sec[6:0]
		|-> !match_now;
	endproperty
	a_cmp: assert property (p_cmp)
		else $error("seconds mismatch still matched");
	property p_bcd;
		@(posedge pclk) disable iff (!presetn)
		$past(year_rollover) && $past(st_reg.century) == 8'h09 && !$past(wr)
		&& !$past(st_reg.hold_dirty) |-> st_reg.century == 8'h10;
	endproperty
	a_bcd: assert property (p_bcd)
		else $error("century BCD carry wrong");
	property p_cal;
		@(posedge pclk) disable iff (!presetn)
		!st_reg.flags[rtcaf_pkg::FLAG_CAL] |-> int_pin == int_request;
	endproperty
	a_cal: assert property (p_cal)
		else $error("interrupt pin not restored");
	property p_cal_wave;
		@(posedge pclk) disable iff (!presetn)
		st_reg.flags[rtcaf_pkg::FLAG_CAL] && cal_tick
		|=> st_reg.cal_wave != $past(st_reg.cal_wave);
	endproperty
	a_cal_wave: assert property (p_cal_wave)
		else $error("calibration wave did not toggle");
	property p_alm_wr;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == rtcaf_pkg::ADDR_ALM_SEC |=> st_reg.alm_sec == $past(pwdata[7:0]);
	endproperty
	a_alm_wr: assert property (p_alm_wr)
		else $error("alarm seconds write lost");
	property p_hold_apply;
		@(posedge pclk) disable iff (!presetn)
		!st_reg.flags[rtcaf_pkg::FLAG_WHOLD] && st_reg.hold_dirty
		|=> st_reg.century == $past(st_reg.century_hold);
	endproperty
	a_hold_apply: assert property (p_hold_apply)
		else $error("staged century not applied");
	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		st_reg.flags[rtcaf_pkg::FLAG_RFREEZE] && $past(st_reg.flags[rtcaf_pkg::FLAG_RFREEZE])
		|-> $stable(st_reg.sec_snap);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("snapshot moved while frozen");
endmodule // rtcaf_top
`default_nettype wire

// file: rtcaf_host.sv
// host model: apb master for the register block
`default_nettype none
module rtcaf_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [19:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 20'h0_0000;
		pwdata = 32'h0000_0000;
	end
	// request held until pready is sampled; only the bench watchdog ends a wait on a dead slave
	task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // rtcaf_host
`default_nettype wire

// file: rtc_alarm_century_flags_tb.sv
// testbench for the alarm, century and flags registers
`default_nettype none
module rtc_alarm_century_flags_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, p0;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata;
	logic other_alarm_match, year_rollover, watchdog_zero, below_switchover, int_request;
	logic int_pin, alarm_match;
	logic [7:0] seconds_now;
	int errors = 0;
	int comparisons = 0;
	int cyc;
	localparam int CAL_T = 8;
	typedef struct {logic [19:0] a; logic [7:0] d; logic [7:0] e; logic err;} rtcaf_row_s;
	rtcaf_row_s rows [3] = '{'{rtcaf_pkg::ADDR_CENTURY, 8'h99, 8'h99, 1'b0},
		'{rtcaf_pkg::ADDR_ALM_SEC, 8'ha5, 8'ha5, 1'b0}, '{20'h7_ffd0, 8'h5a, 8'h00, 1'b1}};
	rtcaf_top #(.SEC_CYCLES(20), .CAL_CYCLES(CAL_T)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.other_alarm_match(other_alarm_match), .year_rollover(year_rollover),
		.watchdog_zero(watchdog_zero), .below_switchover(below_switchover),
		.int_request(int_request), .int_pin(int_pin), .seconds_now(seconds_now),
		.alarm_match(alarm_match));
	rtcaf_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	initial
	begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	task automatic summarize();
		$display("counts: %0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] x);
		logic [31:0] d;
		logic e;
		host.xfer(1, a, {24'h00_0000, x}, d, e);
	endtask
	task automatic rd(input logic [19:0] a, input logic [7:0] x, input logic xe);
		logic [31:0] d;
		logic e;
		host.xfer(0, a, 32'h0000_0000, d, e);
		chk("prdata", d, {24'h00_0000, x});
		chk("pslverr", 32'(e), 32'(xe));
	endtask
	task automatic wait_sec(input logic [7:0] v);
		int n;
		n = 0;
		// let a second already showing v pass, so the match is seen on its way in
		while (seconds_now === v && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		while (seconds_now !== v && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
	endtask
	initial
	begin
		#200_000;
		errors++;
		summarize();
	end
	initial
	begin
		presetn = 0;
		{other_alarm_match, year_rollover, watchdog_zero, below_switchover, int_request} = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		rd(rtcaf_pkg::ADDR_FLAGS, 8'h00, 0);
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h00, 0);
		rd(rtcaf_pkg::ADDR_ALM_SEC, 8'h00, 0);
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e, rows[i].err);
		end
		$display("table test done");
		wr(rtcaf_pkg::ADDR_CENTURY, 8'h99);
		year_rollover <= 1;
		@(posedge pclk);
		year_rollover <= 0;
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h00, 0);
		wr(rtcaf_pkg::ADDR_CENTURY, 8'h09);
		year_rollover <= 1;
		@(posedge pclk);
		year_rollover <= 0;
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h10, 0);
		$display("century test done");
		below_switchover <= 1;
		watchdog_zero <= 1;
		@(posedge pclk);
		below_switchover <= 0;
		watchdog_zero <= 0;
		rd(rtcaf_pkg::ADDR_FLAGS, 8'ha0, 0);
		rd(rtcaf_pkg::ADDR_FLAGS, 8'h00, 0);
		$display("flag test done");
		wr(rtcaf_pkg::ADDR_ALM_SEC, 8'h80);
		other_alarm_match <= 1;
		repeat (3) @(posedge pclk);
		chk("alarm_match", 32'(alarm_match), 32'h0000_0001);
		rd(rtcaf_pkg::ADDR_FLAGS, 8'h40, 0);
		rd(rtcaf_pkg::ADDR_FLAGS, 8'h00, 0);
		wr(rtcaf_pkg::ADDR_ALM_SEC, 8'h03);
		wait_sec(8'h03);
		chk("alarm_match", 32'(alarm_match), 32'h0000_0001);
		rd(rtcaf_pkg::ADDR_FLAGS, 8'h40, 0);
		wait_sec(8'h04);
		chk("alarm_match", 32'(alarm_match), 32'h0000_0000);
		$display("alarm test done");
		other_alarm_match <= 0;
		int_request <= 1;
		repeat (2) @(posedge pclk);
		chk("int_pin", 32'(int_pin), 32'h0000_0001);
		wr(rtcaf_pkg::ADDR_FLAGS, 8'h04);
		p0 = int_pin;
		cyc = 0;
		while (int_pin === p0 && cyc < 100)
		begin
			@(posedge pclk);
			cyc++;
		end
		p0 = int_pin;
		cyc = 0;
		do
		begin
			@(posedge pclk);
			cyc++;
		end
		while (int_pin === p0 && cyc < 100);
		chk("cal_half", 32'(cyc), 32'(CAL_T));
		p0 = int_pin;
		int_request <= 0;
		repeat (2) @(posedge pclk);
		chk("int_pin", 32'(int_pin), 32'(p0));
		wr(rtcaf_pkg::ADDR_FLAGS, 8'h00);
		int_request <= 1;
		repeat (2) @(posedge pclk);
		chk("int_pin", 32'(int_pin), 32'h0000_0001);
		$display("calibration test done");
		wr(rtcaf_pkg::ADDR_FLAGS, 8'h02);
		wr(rtcaf_pkg::ADDR_CENTURY, 8'h42);
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h10, 0);
		wr(rtcaf_pkg::ADDR_FLAGS, 8'h00);
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h42, 0);
		$display("write hold test done");
		wr(rtcaf_pkg::ADDR_FLAGS, 8'h01);
		wr(rtcaf_pkg::ADDR_CENTURY, 8'h55);
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h42, 0);
		wr(rtcaf_pkg::ADDR_FLAGS, 8'h00);
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h55, 0);
		$display("read freeze test done");
		below_switchover <= 1;
		@(posedge pclk);
		below_switchover <= 0;
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		rd(rtcaf_pkg::ADDR_FLAGS, 8'h00, 0);
		rd(rtcaf_pkg::ADDR_ALM_SEC, 8'h00, 0);
		rd(rtcaf_pkg::ADDR_CENTURY, 8'h00, 0);
		$display("mid-run reset test done");
		summarize();
	end
endmodule // rtc_alarm_century_flags_tb
`default_nettype wire
